// *** hdl/tir_irq_logic.v ***
/*
 * interrupt request logic of the transceiver: per-source pending flags,
 * byte counters with fill thresholds, and an AHB-Lite register slave.
 * assumes all event inputs come from logic on clk (no synchronisers),
 * and a single AHB-Lite master with this slave as the only one.
 */
`timescale 1ns/1ps
`include "tir_irq_map.vh"

module tir_irq_logic (
    input wire clk,
    input wire sys_rst,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // status-register flags
    input wire stateFlag,
    input wire powerOn,
    input wire powerOnAux,
    // host operations from the serial interface decoder
    input wire statusRead,
    input wire deleteIrq,
    input wire ctrlRegWrite,
    input wire [2:0] ctrlRegNum,
    input wire rxBufRead,
    input wire rxBufBusy,
    // datapath events
    input wire txByteLoaded,
    input wire txByteSent,
    input wire rxByteStored,
    input wire rxError,
    input wire bitCheckOk,
    // outputs
    output wire irq,
    output reg txBufReset,
    output reg [4:0] txCount,
    output reg [4:0] rxCount
);

    // threshold selector to byte count
    function [4:0] thrValue;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: thrValue = `TIR_THR_0;
                2'h1: thrValue = `TIR_THR_1;
                2'h2: thrValue = `TIR_THR_2;
                default: thrValue = `TIR_THR_3;
            endcase
        end
    endfunction

    // control registers whose write flushes the buffer interrupts
    function clearsBuffer;
        input [2:0] num;
        begin
            clearsBuffer = (num == `TIR_CREG_1) || (num == `TIR_CREG_4) ||
                (num == `TIR_CREG_5) || (num == `TIR_CREG_6);
        end
    endfunction

    reg [5:0] ctrl; // mode, thresholds
    reg [5:0] pend; // sticky per-source flags
    reg [5:0] enable; // per-source gate
    reg stateFlagPrev; // edge history
    reg powerOnPrev;
    reg powerOnAuxPrev;
    reg dataPhase; // a transfer is in its data phase
    reg dataWrite; // that transfer writes
    reg [7:0] dataAddr; // its offset

    // note on the bus side: writes act in the data phase, so a
    // write and a read of the same register back to back see the old
    // value on the read, which is the usual ahb-lite behaviour.
    // only the low byte of the address is decoded, so the register
    // map repeats through the whole slave window.

    wire txMode = ctrl[`TIR_CTRL_TX];
    wire rxMode = ctrl[`TIR_CTRL_RX];
    wire transp = ctrl[`TIR_CTRL_TRANSP];
    wire pattern = ctrl[`TIR_CTRL_PATTERN];
    wire [1:0] thrSel = {ctrl[`TIR_CTRL_THR_HI], ctrl[`TIR_CTRL_THR_LO]};
    wire [4:0] thrCount = thrValue(thrSel);

    // bus write strobes, taken in the data phase with hwdata
    wire busWrite = dataPhase && dataWrite;
    wire wrCtrl = busWrite && (dataAddr == `TIR_OFS_CTRL);
    wire wrEnable = busWrite && (dataAddr == `TIR_OFS_ENABLE);
    wire wrClear = busWrite && (dataAddr == `TIR_OFS_CLEAR);

    // our own control register stands for control register 1
    wire bufFlush = wrCtrl || (ctrlRegWrite && clearsBuffer(ctrlRegNum));

    // buffered operation only when transparent mode is off
    wire txBuffered = txMode && !transp;
    wire rxBuffered = rxMode && !transp;

    // stored bytes and receive errors are masked while the host drains the buffer
    wire rxStoreOk = rxByteStored && !rxBufBusy;
    wire rxErrorOk = rxError && !rxBufBusy;

    // transmit counter reaching the threshold on the way down
    wire txDown = txByteSent && !txByteLoaded && (txCount != `TIR_CNT_RST);
    wire [4:0] txAfter = txCount - `TIR_CNT_ONE;
    wire txEvent = txBuffered && txDown && (txAfter == thrCount);

    // receive fill on the way up; selector 0 picks the error instead
    wire rxUp = rxStoreOk && !rxBufRead && (rxCount != `TIR_CNT_MAX);
    wire [4:0] rxAfter = rxCount + `TIR_CNT_ONE;
    wire rxFill = (thrSel != 2'h0) && rxUp && (rxAfter == thrCount);
    wire rxErrEv = (thrSel == 2'h0) && rxErrorOk;
    wire rxEvent = rxBuffered && (rxFill || rxErrEv);

    // bit check counts only outside pattern mode
    wire bitEvent = rxBuffered && !pattern && bitCheckOk;

    // status-register events
    wire stateEv = stateFlag != stateFlagPrev;
    wire pwrEv = powerOn && !powerOnPrev;
    wire auxEv = powerOnAux && !powerOnAuxPrev;

    // per-source vectors; bit positions follow the status register
    reg [5:0] setVec; // events seen this cycle
    reg [5:0] clrVec; // clears asked for this cycle
    reg [5:0] next_pend; // value of the pending flags after the edge

    // why set wins: an event that lands in the very cycle the host
    // clears would otherwise vanish without a request ever showing,
    // and the host could not learn of it at all.
    // limitation: several events of one source before a clear merge
    // into a single pending flag; the host sees only one request.

    // set and clear vectors per source group
    always @* begin
        setVec = `TIR_PEND_RST;
        setVec[`TIR_SRC_STATE] = stateEv;
        setVec[`TIR_SRC_PWR] = pwrEv;
        setVec[`TIR_SRC_AUX] = auxEv;
        setVec[`TIR_SRC_TX] = txEvent;
        setVec[`TIR_SRC_RX] = rxEvent;
        setVec[`TIR_SRC_BITCHK] = bitEvent;
        // software clear register acts on any bit
        clrVec = wrClear ? hwdata[5:0] : `TIR_PEND_RST;
        // status read clears only the status group
        if (statusRead) begin
            clrVec = clrVec | `TIR_STATUS_GRP;
        end
        // delete command clears every group
        if (deleteIrq) begin
            clrVec = clrVec | `TIR_STATUS_GRP | `TIR_TX_GRP | `TIR_RX_GRP;
        end
        // transmit group: buffer write or control write
        if (txByteLoaded || bufFlush) begin
            clrVec = clrVec | `TIR_TX_GRP;
        end
        // receive group: buffer read or control write
        if (rxBufRead || bufFlush) begin
            clrVec = clrVec | `TIR_RX_GRP;
        end
        // a set in the clearing cycle wins
        next_pend = setVec | (pend & ~clrVec);
    end

    // pending flags and edge history
    always @(posedge clk) begin
        if (sys_rst) begin
            pend <= `TIR_PEND_RST;
            stateFlagPrev <= 1'b0;
            powerOnPrev <= 1'b0;
            powerOnAuxPrev <= 1'b0;
        end else begin
            pend <= next_pend;
            stateFlagPrev <= stateFlag;
            powerOnPrev <= powerOn;
            powerOnAuxPrev <= powerOnAux;
        end
    end

    // request pin: any pending source that is enabled
    // combinational from registered flags, so it cannot glitch on
    // input changes; the enable only masks the pin, never the flags,
    // so a source read back in status stays visible while masked
    assign irq = |(pend & enable);

    // transmit byte counter, flushed by a control write in transmit mode
    always @(posedge clk) begin
        if (sys_rst) begin
            txCount <= `TIR_CNT_RST;
            txBufReset <= 1'b0;
        end else begin
            txBufReset <= bufFlush && txMode;
            if (bufFlush && txMode) begin
                txCount <= `TIR_CNT_RST;
            end else if (txByteLoaded && !txByteSent && txCount != `TIR_CNT_MAX) begin
                txCount <= txCount + `TIR_CNT_ONE;
            end else if (txDown) begin
                txCount <= txAfter;
            end
        end
    end

    // receive byte counter; a stored byte hidden by a read is not counted
    // trade-off: a store and a read in one cycle leave the count alone,
    // which keeps one adder per counter; the counter saturates at the
    // buffer depth and never wraps below zero
    always @(posedge clk) begin
        if (sys_rst) begin
            rxCount <= `TIR_CNT_RST;
        end else if (rxUp) begin
            rxCount <= rxAfter;
        end else if (rxBufRead && !rxStoreOk && rxCount != `TIR_CNT_RST) begin
            rxCount <= rxCount - `TIR_CNT_ONE;
        end
    end

    // ahb-lite: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // an address phase is taken only for nonseq or seq transfers
    // while the bus is ready; idle and busy are ignored
    wire addrPhase = hsel && hready && htrans[1];

    // address phase capture
    always @(posedge clk) begin
        if (sys_rst) begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr <= 8'h00;
        end else if (hready) begin
            dataPhase <= addrPhase;
            dataWrite <= hwrite;
            dataAddr <= haddr[7:0];
        end
    end

    // software registers, written in the data phase
    // the control write also counts as a buffer flush, see bufFlush;
    // the flush uses the mode held before the write lands
    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= `TIR_CTRL_RST;
            enable <= `TIR_ENABLE_RST;
        end else begin
            if (wrCtrl) begin
                ctrl <= hwdata[5:0];
            end
            if (wrEnable) begin
                enable <= hwdata[5:0];
            end
        end
    end

    // read data candidate, chosen from the address phase offset
    // the status read over the bus has no side effect: only the
    // serial host read, on statusRead, clears the status group
    reg [31:0] next_hrdata;

    // read mux, sampled at the address phase; unmapped reads zero
    always @* begin
        next_hrdata = 32'h00000000;
        case (haddr[7:0])
            `TIR_OFS_CTRL: next_hrdata[5:0] = ctrl;
            `TIR_OFS_STATUS: next_hrdata[5:0] = pend;
            `TIR_OFS_ENABLE: next_hrdata[5:0] = enable;
            `TIR_OFS_COUNT: begin
                next_hrdata[4:0] = txCount;
                next_hrdata[`TIR_RXCNT_LSB+4:`TIR_RXCNT_LSB] = rxCount;
            end
            default: next_hrdata = 32'h00000000;
        endcase
    end

    // read data register, loaded for the following data phase
    always @(posedge clk) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

endmodule

// *** hdl/tir_irq_map.vh ***
/*
 * constants of the transceiver interrupt request logic: register offsets,
 * field positions, reset values and source bit numbers.
 * assumes a 32-bit AHB-Lite slave port and one 10 MHz clock.
 */
// What this block does
// - request pin high on any enabled event
// - state flag toggle either way raises request
// - power-on flag rising raises request
// - auxiliary power-on flag rising raises request
// - status read or delete command clears status events
// - status read leaves buffer interrupts pending
// - transmit fill 4/8/12 or empty, selectable
// - transmit write, control write, delete clear it
// - receive fill 4/8/12 or error, selectable
// - bit check success raises unless pattern mode
// - receive read, control write, delete clear it
// - no receive byte or error events while buffer being read
// - transmit counter up on load, down on send
// - control write in transmit resets buffer, count
`ifndef TIR_IRQ_MAP_VH
`define TIR_IRQ_MAP_VH

// register byte offsets
`define TIR_OFS_CTRL 8'h00
`define TIR_OFS_STATUS 8'h04
`define TIR_OFS_ENABLE 8'h08
`define TIR_OFS_CLEAR 8'h0c
`define TIR_OFS_COUNT 8'h10

// control register fields
`define TIR_CTRL_TX 0
`define TIR_CTRL_RX 1
`define TIR_CTRL_TRANSP 2
`define TIR_CTRL_PATTERN 3
`define TIR_CTRL_THR_LO 4
`define TIR_CTRL_THR_HI 5
`define TIR_CTRL_W 6
`define TIR_CTRL_RST 6'h00

// interrupt source bits
`define TIR_SRC_STATE 0
`define TIR_SRC_PWR 1
`define TIR_SRC_AUX 2
`define TIR_SRC_TX 3
`define TIR_SRC_RX 4
`define TIR_SRC_BITCHK 5
`define TIR_SRC_W 6
`define TIR_ENABLE_RST 6'h3f
`define TIR_PEND_RST 6'h00
`define TIR_STATUS_GRP 6'h07
`define TIR_TX_GRP 6'h08
`define TIR_RX_GRP 6'h30

// byte counters
`define TIR_CNT_W 5
`define TIR_CNT_MAX 5'h10
`define TIR_CNT_RST 5'h00
`define TIR_CNT_ONE 5'h01
`define TIR_THR_0 5'h00
`define TIR_THR_1 5'h04
`define TIR_THR_2 5'h08
`define TIR_THR_3 5'h0c
`define TIR_RXCNT_LSB 8

// control register numbers that flush buffer interrupts
`define TIR_CREG_1 3'h1
`define TIR_CREG_4 3'h4
`define TIR_CREG_5 3'h5
`define TIR_CREG_6 3'h6

`endif

// *** tb/tir_irq_chk.sv ***
/* assertions on the request pin of tir_irq_logic, bound to its ports.
   assumes enable bits 0-4 stay set and hsel and hready are held high. */
`timescale 1ns/1ps
module tir_irq_chk (
    input wire clk,
    input wire sys_rst,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire stateFlag,
    input wire powerOn,
    input wire powerOnAux,
    input wire statusRead,
    input wire deleteIrq,
    input wire ctrlRegWrite,
    input wire rxBufRead,
    input wire rxBufBusy,
    input wire txByteLoaded,
    input wire txByteSent,
    input wire rxByteStored,
    input wire rxError,
    input wire bitCheckOk,
    input wire irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    reg [2:0] last; // flag history, cleared by reset as in the block
    reg busW; // register write in its data phase
    // history and bus tracking; reset mirrors the block so first edge agrees
    always @(posedge clk) begin
        last <= sys_rst ? 3'h0 : {powerOnAux, powerOn, stateFlag};
        busW <= !sys_rst && htrans[1] && hwrite;
    end
    wire tgl = stateFlag ^ last[0];
    wire pwrUp = powerOn && !last[1];
    wire auxUp = powerOnAux && !last[2];
    // no cause that could set a source, received bytes and errors aside
    wire noSet = !tgl && !pwrUp && !auxUp && !txByteSent && !bitCheckOk && !busW;
    wire quiet = noSet && !rxByteStored && !rxError;
    wire keep = !busW && !deleteIrq && !statusRead && !txByteLoaded && !rxBufRead && !ctrlRegWrite;
    AST_RST: assert property ($fell(sys_rst) |-> !irq)
        else $error("request high after reset");
    AST_STATE: assert property (tgl |=> irq)
        else $error("state toggle lost");
    AST_PWR: assert property (pwrUp |=> irq)
        else $error("power-on lost");
    AST_AUX: assert property (auxUp |=> irq)
        else $error("aux power-on lost");
    AST_DEL: assert property (deleteIrq && quiet |=> !irq)
        else $error("delete left request high");
    AST_SPUR: assert property (!irq && quiet |=> !irq)
        else $error("request without cause");
    AST_HOLD: assert property (irq && keep |=> irq)
        else $error("request dropped without clear");
    AST_BUSY: assert property (rxBufBusy && !irq && noSet |=> !irq)
        else $error("receive event while buffer read");
    cover property (statusRead && irq ##1 irq);
    cover property (deleteIrq && irq ##1 !irq);
    cover property (rxBufBusy && rxError);
endmodule

// *** tb/tir_host_model.sv ***
/* behavioural host: reads the status register once per request.
   assumes irq comes from the block on the same clock. */
`timescale 1ns/1ps
module tir_host_model (
    input wire clk,
    input wire rst,
    input wire irq,
    input wire en,
    input wire [1:0] lat,
    output reg statusRead = 1'b0
);
    reg [2:0] cnt = 3'h0; // cycles since the request was seen
    // answers lat cycles late, then waits; saturating so it reads only once
    always @(posedge clk) begin
        if (rst || !en || !irq) cnt <= 3'h0;
        else if (cnt != 3'h7) cnt <= cnt + 3'h1;
        statusRead <= en && irq && !rst && cnt == {1'b0, lat};
    end
endmodule

// *** tb/testbench.sv ***
/* self-checking bench of tir_irq_logic with a host model and a checker.
   assumes the slave answers every transfer with hreadyout high. */
`timescale 1ns/1ps
`include "tir_irq_map.vh"
module testbench;
    logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, busy = 1'b0, hostEn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rnd = 32'h4d, got, hrdata;
    logic [1:0] htrans = 2'h0, lat = 2'h0;
    logic [7:0] ev = 8'h0; // event pulses toward the block
    logic [2:0] flags = 3'h0, probe = 3'h0, crn = 3'h0;
    logic hreadyout, irq, txBufReset, statusRead;
    logic [4:0] txCount, rxCount;
    logic [31:0] expq[$]; // expected results, oldest first
    int nFail = 0, totalChecks = 0, i, k;
    tir_irq_logic dut (.clk(clk), .sys_rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .stateFlag(flags[0]), .powerOn(flags[1]),
        .powerOnAux(flags[2]), .statusRead(statusRead), .deleteIrq(ev[6]),
        .ctrlRegWrite(ev[7]), .ctrlRegNum(crn), .rxBufRead(ev[5]), .rxBufBusy(busy),
        .txByteLoaded(ev[0]), .txByteSent(ev[1]), .rxByteStored(ev[2]), .rxError(ev[3]),
        .bitCheckOk(ev[4]), .irq(irq), .txBufReset(txBufReset), .txCount(txCount),
        .rxCount(rxCount));
    tir_host_model host (.clk(clk), .rst(rst), .irq(irq), .en(hostEn), .lat(lat),
        .statusRead(statusRead));
    initial forever #50 clk = ~clk;
    task endOfTest;
        if (nFail == 0 && totalChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task cmp(input [31:0] seen, input [31:0] want);
        totalChecks++;
        if (seen !== want) begin
            nFail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // monitor: mid-cycle, so the outputs have settled
    always @(negedge clk) begin
        if (probe[2]) begin
            case (probe[1:0])
                2'h0: got = {31'h0, irq};
                2'h1: got = hrdata;
                2'h2: got = {19'h0, rxCount, 3'h0, txCount};
                default: got = {31'h0, txBufReset};
            endcase
            cmp(got, expq.pop_front());
        end
    end
    // note an expected value for the current cycle, end after the next edge
    task chk(input [1:0] s, input [31:0] want);
        expq.push_back(want);
        probe = {1'b1, s};
        @(negedge clk);
        #1 probe = 3'h0;
        @(posedge clk);
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one-cycle pulse; a flush is followed by its buffer reset strobe
    task pul(input [7:0] m, input flush);
        ev <= m;
        @(posedge clk);
        ev <= 8'h0;
        if (flush) chk(2'h3, 32'h1);
        else @(posedge clk);
    endtask
    // single word transfer; reads are checked in their data phase
    task xf(input [7:0] a, input wr, input [31:0] d, input [31:0] want);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (wr) do @(posedge clk); while (hreadyout !== 1'b1);
        else chk(2'h1, want);
    endtask
    function logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // watchdog far beyond the few hundred cycles the sequence needs
    initial begin
        #1000000;
        nFail++;
        endOfTest;
    end
    initial begin
        step(3);
        rst <= 1'b0;
        xf(`TIR_OFS_ENABLE, 1'b0, 32'h0, 32'h3f);
        xf(`TIR_OFS_CTRL, 1'b0, 32'h0, 32'h0);
        rnd = xs(rnd);
        xf({3'h7, rnd[2:0], 2'h0}, 1'b1, rnd, 32'h0);
        xf({3'h7, rnd[2:0], 2'h0}, 1'b0, 32'h0, 32'h0);
        // status events, cleared by the host (prompt or slow) or by delete
        for (i = 0; i < 4; i++) begin
            flags <= (i == 3) ? 3'h6 : 3'h7 >> (2 - i);
            step(1);
            chk(2'h0, 32'h1);
            xf(`TIR_OFS_STATUS, 1'b0, 32'h0, (i == 3) ? 32'h1 : 32'h1 << i);
            lat <= i[1:0];
            hostEn <= !i[0];
            if (i[0]) pul(8'h40, 1'b0);
            else step(6);
            hostEn <= 1'b0;
            chk(2'h0, 32'h0);
        end
        // transmit thresholds: empty, 4, 8, 12 while counting down
        for (i = 0; i < 4; i++) begin
            xf(`TIR_OFS_CTRL, 1'b1, {26'h0, i[1:0], 4'h1}, 32'h0);
            for (k = 0; k < 13; k++) pul(8'h01, 1'b0);
            chk(2'h2, 32'hd);
            chk(2'h0, 32'h0);
            for (k = 0; k < 12 - 4 * i; k++) pul(8'h02, 1'b0);
            chk(2'h0, 32'h0);
            pul(8'h02, 1'b0);
            chk(2'h0, 32'h1);
            hostEn <= 1'b1;
            step(6);
            hostEn <= 1'b0;
            chk(2'h0, 32'h1);
            crn <= 3'h4;
            case (i)
                0: pul(8'h01, 1'b0);
                1: pul(8'h80, 1'b1);
                2: pul(8'h40, 1'b0);
                default: xf(`TIR_OFS_CLEAR, 1'b1, 32'h8, 32'h0);
            endcase
            chk(2'h0, 32'h0);
            chk(2'h2, (i == 0) ? 32'h1 : (i == 1) ? 32'h0 : 32'h4 * i);
        end
        // receive error, masked while the buffer is being read
        xf(`TIR_OFS_CTRL, 1'b1, 32'h2, 32'h0);
        busy <= 1'b1;
        pul(8'h08, 1'b0);
        chk(2'h0, 32'h0);
        busy <= 1'b0;
        pul(8'h08, 1'b0);
        chk(2'h0, 32'h1);
        crn <= 3'h6;
        pul(8'h80, 1'b0);
        chk(2'h0, 32'h0);
        for (i = 1; i < 4; i++) begin
            xf(`TIR_OFS_CTRL, 1'b1, {26'h0, i[1:0], 4'h2}, 32'h0);
            for (k = 1; k < 4 * i; k++) pul(8'h04, 1'b0);
            chk(2'h0, 32'h0);
            pul(8'h04, 1'b0);
            chk(2'h0, 32'h1);
            chk(2'h2, 32'h400 * i);
            for (k = 0; k < 4 * i; k++) pul(8'h20, 1'b0);
            chk(2'h0, 32'h0);
        end
        // bit check: off in pattern mode, receive events off when transparent
        xf(`TIR_OFS_CTRL, 1'b1, 32'ha, 32'h0);
        pul(8'h10, 1'b0);
        chk(2'h0, 32'h0);
        xf(`TIR_OFS_CTRL, 1'b1, 32'h6, 32'h0);
        pul(8'h18, 1'b0);
        chk(2'h0, 32'h0);
        xf(`TIR_OFS_ENABLE, 1'b1, 32'h1f, 32'h0);
        xf(`TIR_OFS_CTRL, 1'b1, 32'h2, 32'h0);
        pul(8'h10, 1'b0);
        chk(2'h0, 32'h0);
        xf(`TIR_OFS_STATUS, 1'b0, 32'h0, 32'h20);
        xf(`TIR_OFS_ENABLE, 1'b1, 32'h3f, 32'h0);
        flags <= 3'h7;
        step(1);
        xf(`TIR_OFS_STATUS, 1'b0, 32'h0, 32'h21);
        hostEn <= 1'b1;
        step(6);
        hostEn <= 1'b0;
        chk(2'h0, 32'h1);
        xf(`TIR_OFS_CLEAR, 1'b1, 32'h20, 32'h0);
        chk(2'h0, 32'h0);
        endOfTest;
    end
endmodule
bind tir_irq_logic tir_irq_chk chk (.clk(clk), .sys_rst(sys_rst), .htrans(htrans),
    .hwrite(hwrite), .stateFlag(stateFlag), .powerOn(powerOn), .powerOnAux(powerOnAux),
    .statusRead(statusRead), .deleteIrq(deleteIrq), .ctrlRegWrite(ctrlRegWrite),
    .rxBufRead(rxBufRead), .rxBufBusy(rxBufBusy), .txByteLoaded(txByteLoaded),
    .txByteSent(txByteSent), .rxByteStored(rxByteStored), .rxError(rxError),
    .bitCheckOk(bitCheckOk), .irq(irq));
